// ---- intr_front_defs.svh ----
`ifndef INTR_FRONT_DEFS_SVH
`define INTR_FRONT_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_EDGE_SELECT    8'h3a
`define IDX_PENDING_SECOND 8'h3d
`define IDX_ENABLE_FIRST   8'h3e
`define IDX_EVENT_STATUS   8'h40
`define IDX_EVENT_MASK     8'h41

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_EDGE_SELECT    8'h00
`define RST_PENDING_SECOND 7'h00
`define RST_ENABLE_FIRST   8'h00
`define RST_EVENT_STATUS   8'h00
`define RST_EVENT_MASK     8'h00

// ----------------------------------------
// edge select fields
// ----------------------------------------
`define EDGE_PIN_LSB       0
`define EDGE_PIN_MSB       3
`define EDGE_RESERVED_BIT  4

// ----------------------------------------
// enable / event status layout
// ----------------------------------------
`define SRC_EXT_ZERO       0
`define SRC_SCL_SDA        1
`define SRC_EXT_ONE        2
`define SRC_EXT_TWO        3
`define SRC_EXT_THREE      4
`define SRC_I2C            5
`define SRC_TIMER_X        6
`define SRC_TIMER_Y        7

// ----------------------------------------
// second request layout
// ----------------------------------------
`define REQ_TIMER_ONE      0
`define REQ_TIMER_TWO      1
`define REQ_SERIAL_RX      2
`define REQ_SERIAL_TX      3
`define REQ_COUNTER_ZERO   4
`define REQ_COUNTER_ONE    5
`define REQ_ADC_DONE       6

`endif

// ---- intr_front_pkg.sv ----
package intr_front_pkg;

    typedef logic [7:0] reg_byte_t;

    typedef enum logic [1:0] {
        ApbIdle = 2'b00,
        ApbDone = 2'b01
    } apb_state_t;

endpackage : intr_front_pkg

// ---- pin_edge_detect.sv ----
`timescale 1ns/1ps

module pin_edge_detect #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pinIn,
    input  wire logic [WIDTH-1:0] risingSel,
    output logic      [WIDTH-1:0] edgePulse
);

    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] edgePulse_q;

    // ----------------------------------------
    // two stage synchroniser
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // ----------------------------------------
    // polarity selected edge
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            edgePulse_q <= '0;
        end else begin
            edgePulse_q <= (risingSel & sync2_q & ~prev_q)
                         | (~risingSel & ~sync2_q & prev_q); // see RULE1
        end
    end

    assign edgePulse = edgePulse_q;

endmodule : pin_edge_detect

// ---- sticky_flags.sv ----
`timescale 1ns/1ps

module sticky_flags #(
    parameter int WIDTH        = 8,
    parameter bit CLEAR_ON_ONE = 1'b1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] setPulse,
    input  wire logic             clearWrite,
    input  wire logic [WIDTH-1:0] writeData,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] clearMask;

    // ----------------------------------------
    // clear selection
    // ----------------------------------------
    always_comb begin
        if (!clearWrite) begin
            clearMask = '0;
        end else if (CLEAR_ON_ONE) begin
            clearMask = writeData;
        end else begin
            clearMask = ~writeData; // see RULE12
        end
    end

    // ----------------------------------------
    // set wins over clear
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            flags_q <= '0; // see RULE6
        end else begin
            flags_q <= (flags_q & ~clearMask) | setPulse; // see RULE12
        end
    end

    assign flags = flags_q;

endmodule : sticky_flags

// ---- interrupt_edge_request_enable.sv ----
`timescale 1ns/1ps
`include "intr_front_defs.svh"

// Behaviour
// RULE1: edge bits 0-3: 0 falling, 1 rising
// RULE2: software never writes one to bit 4
// RULE3: edge bits 5-7 ignore writes, read zero
// RULE4: request bits 0-3: timers, serial rx/tx
// RULE5: request bits 4-6: counter pins, converter
// RULE6: request bit one when pending; reset clears
// RULE7: request bit 7 unwritable, reads zero
// RULE8: enable bits 0-4: pins and line source
// RULE9: enable bits 5-7: i2c, timer X, Y
// RULE10: enable one allows source; reset disables
// RULE11: timer X enable fully read/write
// RULE12: hardware sets requests; write zero clears
// RULE13: interrupt only when request and enable

module interrupt_edge_request_enable #(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  extIrqPinZero,
    input  wire logic                  extIrqPinOne,
    input  wire logic                  extIrqPinTwo,
    input  wire logic                  extIrqPinThree,
    input  wire logic                  sclSdaEvent,
    input  wire logic                  i2cEvent,
    input  wire logic                  timerXEvent,
    input  wire logic                  timerYEvent,
    input  wire logic                  timerOneEvent,
    input  wire logic                  timerTwoEvent,
    input  wire logic                  serialRxEvent,
    input  wire logic                  serialTxEvent,
    input  wire logic                  counterPinZeroEvent,
    input  wire logic                  counterPinOneEvent,
    input  wire logic                  adcDoneEvent,
    output logic      [7:0]            enabledRequest,
    output logic      [6:0]            pendingSecond,
    output logic                       irqOut
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    intr_front_pkg::apb_state_t apbState_q;
    intr_front_pkg::apb_state_t apbState_d;

    intr_front_pkg::reg_byte_t  edgeSelect_q;
    intr_front_pkg::reg_byte_t  enableFirst_q;
    intr_front_pkg::reg_byte_t  eventMask_q;
    intr_front_pkg::reg_byte_t  eventStatus;
    intr_front_pkg::reg_byte_t  readByte;
    intr_front_pkg::reg_byte_t  sourceEvent;

    logic [6:0]  pendingFlags;
    logic [6:0]  secondEvent;
    logic [3:0]  extPins;
    logic [3:0]  extEdge;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irqOut_q;
    logic [7:0]  enabledRequest_q;
    logic [6:0]  pendingSecond_q;
    logic        accessPhase;
    logic        firstAccess;
    logic        writeCommit;
    logic        addrHit;
    logic        wrEdge;
    logic        wrPending;
    logic        wrEnable;
    logic        wrStatus;
    logic        wrMask;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic isReg(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [7:0]            idx
    );
        logic [ADDR_WIDTH-1:0] byteAddr;
        byteAddr = ADDR_WIDTH'({idx, 2'b00});
        return addr == byteAddr;
    endfunction : isReg

    function automatic logic isMapped(
        input logic [ADDR_WIDTH-1:0] addr
    );
        return isReg(addr, `IDX_EDGE_SELECT)
            || isReg(addr, `IDX_PENDING_SECOND)
            || isReg(addr, `IDX_ENABLE_FIRST)
            || isReg(addr, `IDX_EVENT_STATUS)
            || isReg(addr, `IDX_EVENT_MASK);
    endfunction : isMapped

    // ----------------------------------------
    // source gating
    // ----------------------------------------
    function automatic intr_front_pkg::reg_byte_t gateEnabled(
        input intr_front_pkg::reg_byte_t status,
        input intr_front_pkg::reg_byte_t enable
    );
        return status & enable;
    endfunction : gateEnabled

    // ----------------------------------------
    // apb handshake
    // ----------------------------------------
    assign accessPhase = psel && penable;
    assign writeCommit = accessPhase && pready_q && pwrite && pstrb[0];
    assign addrHit     = isMapped(paddr);
    assign firstAccess = apbState_q == intr_front_pkg::ApbIdle
                         && accessPhase;

    always_comb begin
        apbState_d = apbState_q;
        unique case (apbState_q)
            intr_front_pkg::ApbIdle: begin
                if (accessPhase) begin
                    apbState_d = intr_front_pkg::ApbDone;
                end
            end
            intr_front_pkg::ApbDone: begin
                apbState_d = intr_front_pkg::ApbIdle;
            end
            default: begin
                apbState_d = intr_front_pkg::ApbIdle;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            apbState_q <= intr_front_pkg::ApbIdle;
        end else begin
            apbState_q <= apbState_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (firstAccess) begin
            pready_q  <= 1'b1;
            pslverr_q <= !addrHit;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // write strobes
    // ----------------------------------------
    assign wrEdge    = writeCommit && isReg(paddr, `IDX_EDGE_SELECT);
    assign wrPending = writeCommit && isReg(paddr, `IDX_PENDING_SECOND);
    assign wrEnable  = writeCommit && isReg(paddr, `IDX_ENABLE_FIRST);
    assign wrStatus  = writeCommit && isReg(paddr, `IDX_EVENT_STATUS);
    assign wrMask    = writeCommit && isReg(paddr, `IDX_EVENT_MASK);

    // ----------------------------------------
    // edge select register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            edgeSelect_q <= `RST_EDGE_SELECT;
        end else if (wrEdge) begin
            edgeSelect_q[`EDGE_PIN_MSB:`EDGE_PIN_LSB] <=
                pwdata[`EDGE_PIN_MSB:`EDGE_PIN_LSB]; // see RULE1
            edgeSelect_q[`EDGE_RESERVED_BIT] <=
                pwdata[`EDGE_RESERVED_BIT]; // see RULE2
            edgeSelect_q[7:`EDGE_RESERVED_BIT+1] <= 3'h0; // see RULE3
        end
    end

    // ----------------------------------------
    // enable and mask registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            enableFirst_q <= `RST_ENABLE_FIRST; // see RULE10
        end else if (wrEnable) begin
            enableFirst_q <= pwdata[7:0]; // see RULE8 see RULE9 see RULE11
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            eventMask_q <= `RST_EVENT_MASK;
        end else if (wrMask) begin
            eventMask_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // external pin edges
    // ----------------------------------------
    assign extPins = {extIrqPinThree, extIrqPinTwo,
                      extIrqPinOne, extIrqPinZero};

    pin_edge_detect #(
        .WIDTH (4)
    ) u_pin_edge_detect (
        .clock     (clock),
        .reset     (reset),
        .pinIn     (extPins),
        .risingSel (edgeSelect_q[`EDGE_PIN_MSB:`EDGE_PIN_LSB]),
        .edgePulse (extEdge)
    );

    // ----------------------------------------
    // event status flags
    // ----------------------------------------
    always_comb begin
        sourceEvent                 = '0;
        sourceEvent[`SRC_EXT_ZERO]  = extEdge[0];
        sourceEvent[`SRC_SCL_SDA]   = sclSdaEvent;
        sourceEvent[`SRC_EXT_ONE]   = extEdge[1];
        sourceEvent[`SRC_EXT_TWO]   = extEdge[2];
        sourceEvent[`SRC_EXT_THREE] = extEdge[3];
        sourceEvent[`SRC_I2C]       = i2cEvent;
        sourceEvent[`SRC_TIMER_X]   = timerXEvent;
        sourceEvent[`SRC_TIMER_Y]   = timerYEvent;
    end

    sticky_flags #(
        .WIDTH        (8),
        .CLEAR_ON_ONE (1'b1)
    ) u_event_status (
        .clock      (clock),
        .reset      (reset),
        .setPulse   (sourceEvent),
        .clearWrite (wrStatus),
        .writeData  (pwdata[7:0]),
        .flags      (eventStatus)
    );

    // ----------------------------------------
    // second request register
    // ----------------------------------------
    always_comb begin
        secondEvent                    = '0;
        secondEvent[`REQ_TIMER_ONE]    = timerOneEvent; // see RULE4
        secondEvent[`REQ_TIMER_TWO]    = timerTwoEvent;
        secondEvent[`REQ_SERIAL_RX]    = serialRxEvent;
        secondEvent[`REQ_SERIAL_TX]    = serialTxEvent;
        secondEvent[`REQ_COUNTER_ZERO] = counterPinZeroEvent; // see RULE5
        secondEvent[`REQ_COUNTER_ONE]  = counterPinOneEvent;
        secondEvent[`REQ_ADC_DONE]     = adcDoneEvent;
    end

    sticky_flags #(
        .WIDTH        (7),
        .CLEAR_ON_ONE (1'b0)
    ) u_pending_second (
        .clock      (clock),
        .reset      (reset),
        .setPulse   (secondEvent),
        .clearWrite (wrPending),
        .writeData  (pwdata[6:0]),
        .flags      (pendingFlags)
    ); // see RULE6 see RULE12

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        readByte = '0;
        if (isReg(paddr, `IDX_EDGE_SELECT)) begin
            readByte = {3'h0, edgeSelect_q[4:0]}; // see RULE3
        end else if (isReg(paddr, `IDX_PENDING_SECOND)) begin
            readByte = {1'b0, pendingFlags}; // see RULE7
        end else if (isReg(paddr, `IDX_ENABLE_FIRST)) begin
            readByte = enableFirst_q; // see RULE11
        end else if (isReg(paddr, `IDX_EVENT_STATUS)) begin
            readByte = eventStatus;
        end else if (isReg(paddr, `IDX_EVENT_MASK)) begin
            readByte = eventMask_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (firstAccess && !pwrite) begin
            prdata_q <= {24'h00_0000, readByte};
        end
    end

    // ----------------------------------------
    // interrupt outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            enabledRequest_q <= 8'h00;
        end else begin
            enabledRequest_q <= gateEnabled(eventStatus,
                                            enableFirst_q); // see RULE13
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irqOut_q <= 1'b0;
        end else begin
            irqOut_q <= |(gateEnabled(eventStatus, enableFirst_q)
                          & eventMask_q); // see RULE10 see RULE13
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pendingSecond_q <= 7'h00;
        end else begin
            pendingSecond_q <= pendingFlags;
        end
    end

    // ----------------------------------------
    // output drive
    // ----------------------------------------
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign enabledRequest = enabledRequest_q;
    assign pendingSecond  = pendingSecond_q;
    assign irqOut         = irqOut_q;

endmodule : interrupt_edge_request_enable

// ---- intr_front_asserts.sv ----
`timescale 1ns/1ps
`include "intr_front_defs.svh"

module intr_front_asserts #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  clock,
    input wire logic                  reset,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  timerOneEvent,
    input wire logic [7:0]            enabledRequest,
    input wire logic [6:0]            pendingSecond,
    input wire logic                  irqOut
);
    localparam logic [11:0] EDGE_A = {2'h0, `IDX_EDGE_SELECT, 2'h0};
    localparam logic [11:0] PEND_A = {2'h0, `IDX_PENDING_SECOND, 2'h0};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("no answer after one wait state");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_upper;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    property p_edge_hi;
        pready && !pwrite && paddr == EDGE_A |-> prdata[7:5] == 3'h0;
    endproperty
    a_edge_hi: assert property (p_edge_hi)
        else $error("edge select bits 7:5 not zero");
    property p_pend_top;
        pready && !pwrite && paddr == PEND_A |-> !prdata[7];
    endproperty
    a_pend_top: assert property (p_pend_top)
        else $error("request bit 7 not zero");

    // ----------------------------------------
    // requests and interrupt
    // ----------------------------------------
    property p_irq_cause;
        irqOut |-> enabledRequest != 8'h00;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled request");
    property p_reset_clear;
        disable iff (1'b0)
        reset |=> enabledRequest == 8'h00 && pendingSecond == 7'h00 && !irqOut;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");
    property p_timer_one;
        timerOneEvent |-> ##[1:3] pendingSecond[0];
    endproperty
    a_timer_one: assert property (p_timer_one)
        else $error("timer one request not latched");

    c_irq: cover property ($rose(irqOut));
    c_err: cover property (pslverr);
    c_pend: cover property (pendingSecond == 7'h7f);
endmodule : intr_front_asserts

bind interrupt_edge_request_enable intr_front_asserts #(
    .ADDR_WIDTH(ADDR_WIDTH)
) u_intr_front_asserts (
    .clock, .reset, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .timerOneEvent, .enabledRequest, .pendingSecond, .irqOut
);

// ---- irq_source_model.sv ----
`timescale 1ns/1ps

module irq_source_model (
    input  wire logic       clock,
    output logic      [3:0] pinLevel,
    output logic      [6:0] reqPulse,
    output logic      [3:0] ctlPulse
);
    initial begin
        pinLevel = 4'h0;
        reqPulse = 7'h00;
        ctlPulse = 4'h0;
    end

    task automatic set_pins(input logic [3:0] lvl);
        @(posedge clock);
        pinLevel <= lvl;
    endtask : set_pins

    task automatic fire(input logic [6:0] req, input logic [3:0] ctl);
        @(posedge clock);
        reqPulse <= req;
        ctlPulse <= ctl;
        @(posedge clock);
        reqPulse <= 7'h00;
        ctlPulse <= 4'h0;
    endtask : fire
endmodule : irq_source_model

// ---- tb.sv ----
`timescale 1ns/1ps
`include "intr_front_defs.svh"

module tb;
    localparam logic [11:0] EDGE_A = {2'h0, `IDX_EDGE_SELECT, 2'h0};
    localparam logic [11:0] PEND_A = {2'h0, `IDX_PENDING_SECOND, 2'h0};
    localparam logic [11:0] EN_A   = {2'h0, `IDX_ENABLE_FIRST, 2'h0};
    localparam logic [11:0] STAT_A = {2'h0, `IDX_EVENT_STATUS, 2'h0};
    localparam logic [11:0] MASK_A = {2'h0, `IDX_EVENT_MASK, 2'h0};
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pinLevel;
    logic [6:0]  reqPulse;
    logic [3:0]  ctlPulse;
    logic [7:0]  enabledRequest;
    logic [6:0]  pendingSecond;
    logic        irqOut;
    logic [6:0]  expPend;
    int          checks = 0;
    int          mismatches = 0;

    always #2.5 clock = ~clock;

    interrupt_edge_request_enable #(
        .ADDR_WIDTH(12)
    ) u_interrupt_edge_request_enable (
        .clock, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr,
        .extIrqPinZero(pinLevel[0]), .extIrqPinOne(pinLevel[1]),
        .extIrqPinTwo(pinLevel[2]), .extIrqPinThree(pinLevel[3]),
        .sclSdaEvent(ctlPulse[0]), .i2cEvent(ctlPulse[1]),
        .timerXEvent(ctlPulse[2]), .timerYEvent(ctlPulse[3]),
        .timerOneEvent(reqPulse[0]), .timerTwoEvent(reqPulse[1]),
        .serialRxEvent(reqPulse[2]), .serialTxEvent(reqPulse[3]),
        .counterPinZeroEvent(reqPulse[4]), .counterPinOneEvent(reqPulse[5]),
        .adcDoneEvent(reqPulse[6]),
        .enabledRequest, .pendingSecond, .irqOut
    );

    irq_source_model u_irq_source_model (
        .clock, .pinLevel, .reqPulse, .ctlPulse
    );

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'h1);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, s, r, e);
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [7:0] ex, input logic er = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        chk(nm, {24'h0, ex}, r);
        chk("slave error", {31'h0, er}, {31'h0, e});
    endtask : rd

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd("edge", EDGE_A, 8'h00);
        rd("pend", PEND_A, 8'h00);
        rd("enable", EN_A, 8'h00);
        rd("status", STAT_A, 8'h00);
        rd("mask", MASK_A, 8'h00);
        rd("unmapped", 12'h0f0, 8'h00, 1'b1);
        wr(EDGE_A, 8'he5);
        rd("edge", EDGE_A, 8'h05);
        wr(EN_A, 8'hff);
        wr(EN_A, 8'h00, 4'h0);
        rd("enable", EN_A, 8'hff);
        wr(MASK_A, 8'hff);
        u_irq_source_model.set_pins(4'hf);
        repeat (6) @(negedge clock);
        rd("status", STAT_A, 8'h09);
        chk("irq", 32'h1, {31'h0, irqOut});
        wr(STAT_A, 8'hff);
        u_irq_source_model.set_pins(4'h0);
        repeat (6) @(negedge clock);
        rd("status", STAT_A, 8'h14);
        u_irq_source_model.fire(7'h00, 4'hf);
        repeat (3) @(negedge clock);
        rd("status", STAT_A, 8'hf6);
        chk("request", 32'hf6, {24'h0, enabledRequest});
        wr(EN_A, 8'h00);
        repeat (3) @(negedge clock);
        chk("irq", 32'h0, {31'h0, irqOut});
        wr(EN_A, 8'h40);
        rd("enable", EN_A, 8'h40);
        chk("request", 32'h40, {24'h0, enabledRequest});
        chk("irq", 32'h1, {31'h0, irqOut});
        wr(MASK_A, 8'h00);
        repeat (3) @(negedge clock);
        chk("irq", 32'h0, {31'h0, irqOut});
        expPend = 7'h00;
        for (int i = 0; i < 7; i++) begin
            u_irq_source_model.fire(7'h01 << i, 4'h0);
            expPend[i] = 1'b1;
            repeat (3) @(negedge clock);
            chk("pend", {25'h0, expPend}, {25'h0, pendingSecond});
            rd("pend", PEND_A, {1'b0, expPend});
        end
        wr(PEND_A, 8'hfe);
        rd("pend", PEND_A, 8'h7e);
        u_irq_source_model.fire(7'h40, 4'h0);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd("pend", PEND_A, 8'h00);
        rd("enable", EN_A, 8'h00);
        print_verdict();
    end

    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        print_verdict();
    end
endmodule : tb
